/* hdl/pfc_consts.vh */
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH

// Clock rate and blanking time
`define PFC_CLK_MHZ 25
`define PFC_LEB_NS 200
`define PFC_NS_PER_US 1000

// Synchroniser depth and flag vector layout
`define PFC_SYNC_STAGES 2
`define PFC_NUM_FLAGS 12
`define PFC_F_SUPPLY_ON 0
`define PFC_F_SUPPLY_OFF 1
`define PFC_F_SLEEP_REQ 2
`define PFC_F_BO_RELEASE 3
`define PFC_F_BO_TRIP 4
`define PFC_F_OPEN_LOOP 5
`define PFC_F_OV_TRIP 6
`define PFC_F_OV_RELEASE 7
`define PFC_F_PEAK 8
`define PFC_F_COMP_LOW 9
`define PFC_F_COMP_TOP 10
`define PFC_F_PWM 11

// Mode encodings
`define PFC_MODE_W 3
`define PFC_MODE_SLEEP 3'h0
`define PFC_MODE_STANDBY 3'h1
`define PFC_MODE_SOFT 3'h2
`define PFC_MODE_NORMAL 3'h3
`define PFC_MODE_OVERV 3'h4
`define PFC_MODE_PEAK 3'h5
`define PFC_MODE_DISCH 3'h6

// APB map
`define PFC_ADDR_W 12
`define PFC_OFS_CTRL 12'h000
`define PFC_OFS_STATUS 12'h004
`define PFC_CTRL_RESET 32'h00000000

// Control fields
`define PFC_CTRL_SLEEP 0

// Status fields
`define PFC_ST_MODE_LSB 0
`define PFC_ST_GATE 4
`define PFC_ST_BIAS 5
`define PFC_ST_DISCH 6
`define PFC_ST_UV 8
`define PFC_ST_BO 9
`define PFC_ST_OL 10
`define PFC_ST_OV 11
`define PFC_ST_PEAK 12
`define PFC_ST_BLANK 13

`endif

/* hdl/pfc_mode_ctrl.v */
// Function
// - Sleep on low supply or sleep pin
// - Sleep reachable everywhere, pin forces it
// - Sleep: gate off, bias withdrawn
// - Pin sleep discharges error amp first
// - Standby on open loop or brown-out
// - Brown-out release before start, trip after
// - Open loop flagged in every mode
// - Standby: biased, gate off
// - Standby reachable from every mode
// - Soft-start needs all levels, low error amp
// - Soft-start done enters normal, gate switching
// - Leaving run for an idle mode discharges error amp
// - Overvoltage trip forces gate off
// - Overvoltage exit below release level
// - Fault modes only from soft or normal
// - Peak current forces gate off
// - Peak current exit when below level
// - Gate off while error amp low
// - Blank peak flag after gate turn-on
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_mode_ctrl #(
    parameter CLK_MHZ = `PFC_CLK_MHZ,
    parameter LEB_NS = `PFC_LEB_NS
) (
    // Clock and undervoltage reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PFC_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // Comparator flags
    input wire supply_above_on,
    input wire supply_below_off,
    input wire enable_below_sleep,
    input wire brownout_below_release,
    input wire brownout_below_trip,
    input wire feedback_below_open_loop,
    input wire enable_above_ov_trip,
    input wire enable_below_ov_release,
    input wire current_above_peak,
    input wire comp_below_start,
    input wire comp_at_top,
    // Oscillator duty request
    input wire pwm_request,
    // Power stage controls
    output reg gate_drive_ff,
    output reg bias_enable_ff,
    output reg comp_discharge_ff,
    output reg [`PFC_MODE_W-1:0] mode_ff
);

    // Mode states
    localparam [2:0] ST_SLEEP = `PFC_MODE_SLEEP;
    localparam [2:0] ST_STANDBY = `PFC_MODE_STANDBY;
    localparam [2:0] ST_SOFT = `PFC_MODE_SOFT;
    localparam [2:0] ST_NORMAL = `PFC_MODE_NORMAL;
    localparam [2:0] ST_OVERV = `PFC_MODE_OVERV;
    localparam [2:0] ST_PEAK = `PFC_MODE_PEAK;
    localparam [2:0] ST_DISCH = `PFC_MODE_DISCH;

    // Blanking length, rounded up, never below one cycle
    localparam integer LEB_RAW =
        (LEB_NS * CLK_MHZ + `PFC_NS_PER_US - 1) / `PFC_NS_PER_US;
    localparam integer LEB_CYC = (LEB_RAW < 1) ? 1 : LEB_RAW;
    localparam integer LEB_W = 8;
    localparam [LEB_W-1:0] LEB_LOAD = LEB_CYC[LEB_W-1:0];
    localparam [LEB_W-1:0] LEB_ZERO = {LEB_W{1'b0}};

    // Synchronised flags
    wire [`PFC_NUM_FLAGS-1:0] raw_flags;
    wire [`PFC_NUM_FLAGS-1:0] flags;

    assign raw_flags[`PFC_F_SUPPLY_ON] = supply_above_on;
    assign raw_flags[`PFC_F_SUPPLY_OFF] = supply_below_off;
    assign raw_flags[`PFC_F_SLEEP_REQ] = enable_below_sleep;
    assign raw_flags[`PFC_F_BO_RELEASE] = brownout_below_release;
    assign raw_flags[`PFC_F_BO_TRIP] = brownout_below_trip;
    assign raw_flags[`PFC_F_OPEN_LOOP] = feedback_below_open_loop;
    assign raw_flags[`PFC_F_OV_TRIP] = enable_above_ov_trip;
    assign raw_flags[`PFC_F_OV_RELEASE] = enable_below_ov_release;
    assign raw_flags[`PFC_F_PEAK] = current_above_peak;
    assign raw_flags[`PFC_F_COMP_LOW] = comp_below_start;
    assign raw_flags[`PFC_F_COMP_TOP] = comp_at_top;
    assign raw_flags[`PFC_F_PWM] = pwm_request;

    pfc_sync #(
        .WIDTH(`PFC_NUM_FLAGS)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(raw_flags),
        .sync_out(flags)
    );

    wire s_on = flags[`PFC_F_SUPPLY_ON];
    wire s_off = flags[`PFC_F_SUPPLY_OFF];
    wire s_sleep = flags[`PFC_F_SLEEP_REQ];
    wire s_bo_rel = flags[`PFC_F_BO_RELEASE];
    wire s_bo_trip = flags[`PFC_F_BO_TRIP];
    wire s_ol = flags[`PFC_F_OPEN_LOOP];
    wire s_ov_trip = flags[`PFC_F_OV_TRIP];
    wire s_ov_rel = flags[`PFC_F_OV_RELEASE];
    wire s_peak = flags[`PFC_F_PEAK];
    wire s_comp_low = flags[`PFC_F_COMP_LOW];
    wire s_comp_top = flags[`PFC_F_COMP_TOP];
    wire s_pwm = flags[`PFC_F_PWM];

    // State
    reg supply_ok_ff;
    reg line_ok_ff;
    reg ret_normal_ff;
    reg [LEB_W-1:0] leb_cnt_ff;
    reg [31:0] ctrl_ff;
    reg [`PFC_MODE_W-1:0] nxt_mode;
    reg nxt_supply_ok;
    reg nxt_line_ok;
    reg nxt_gate;

    function is_run;
        input [`PFC_MODE_W-1:0] m;
        begin
            is_run = (m == ST_SOFT) || (m == ST_NORMAL);
        end
    endfunction

    // Hysteresis on supply: on-level sets, off-level clears
    always @*
    begin
        nxt_supply_ok = supply_ok_ff;
        if (s_off)
            nxt_supply_ok = 1'b0;
        else if (s_on)
            nxt_supply_ok = 1'b1;
    end

    // Line is armed above release, disarmed only below trip
    always @*
    begin
        nxt_line_ok = line_ok_ff;
        if (!s_bo_rel)
            nxt_line_ok = 1'b1;
        else if (s_bo_trip)
            nxt_line_ok = 1'b0;
    end

    wire undervolt = !supply_ok_ff;
    wire sleep_req = s_sleep || ctrl_ff[`PFC_CTRL_SLEEP];
    wire brownout = !line_ok_ff;
    wire open_loop = s_ol;
    wire blanking = (leb_cnt_ff != LEB_ZERO);
    wire peak_hit = s_peak && !blanking;
    wire start_ok = supply_ok_ff && !s_ol && line_ok_ff && s_comp_low;

    // Mode selection, priority sleep > standby > faults > run
    always @*
    begin
        nxt_mode = mode_ff;
        if (undervolt)
        begin
            nxt_mode = ST_SLEEP;
        end
        else if (sleep_req)
        begin
            // Pin sleep waits for the error amp to discharge
            if (mode_ff == ST_SLEEP || s_comp_low)
                nxt_mode = ST_SLEEP;
            else
                nxt_mode = ST_DISCH;
        end
        else if (open_loop || brownout)
        begin
            nxt_mode = ST_STANDBY;
        end
        else
        begin
            case (mode_ff)
                ST_SLEEP, ST_STANDBY, ST_DISCH:
                begin
                    // No fault entry from here
                    if (start_ok)
                        nxt_mode = ST_SOFT;
                    else
                        nxt_mode = ST_STANDBY;
                end
                ST_SOFT:
                begin
                    if (s_ov_trip)
                        nxt_mode = ST_OVERV;
                    else if (peak_hit)
                        nxt_mode = ST_PEAK;
                    else if (s_comp_top)
                        nxt_mode = ST_NORMAL;
                end
                ST_NORMAL:
                begin
                    if (s_ov_trip)
                        nxt_mode = ST_OVERV;
                    else if (peak_hit)
                        nxt_mode = ST_PEAK;
                end
                ST_OVERV:
                begin
                    if (s_ov_rel)
                        nxt_mode = ret_normal_ff ? ST_NORMAL : ST_SOFT;
                end
                ST_PEAK:
                begin
                    if (!s_peak)
                        nxt_mode = ret_normal_ff ? ST_NORMAL : ST_SOFT;
                end
                default:
                begin
                    nxt_mode = ST_STANDBY;
                end
            endcase
        end
    end

    // Gate follows the duty request only in run modes, amp above start
    always @*
    begin
        nxt_gate = s_pwm && is_run(nxt_mode) && !s_comp_low;
    end

    // Mode, supply and line tracking
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_ff <= ST_SLEEP;
            supply_ok_ff <= 1'b0;
            line_ok_ff <= 1'b0;
            ret_normal_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            supply_ok_ff <= nxt_supply_ok;
            line_ok_ff <= nxt_line_ok;
            if (is_run(mode_ff))
                ret_normal_ff <= (mode_ff == ST_NORMAL);
        end
    end

    // Power stage controls; gate falls in the same edge as a fault
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gate_drive_ff <= 1'b0;
            bias_enable_ff <= 1'b0;
            comp_discharge_ff <= 1'b0;
        end
        else
        begin
            gate_drive_ff <= nxt_gate;
            bias_enable_ff <= (nxt_mode != ST_SLEEP);
            // Discharge in every idle mode so restart goes soft
            comp_discharge_ff <= !is_run(nxt_mode) &&
                (nxt_mode != ST_OVERV) && (nxt_mode != ST_PEAK) &&
                !s_comp_low;
        end
    end

    // Blanking window loads on each gate turn-on
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            leb_cnt_ff <= LEB_ZERO;
        else if (nxt_gate && !gate_drive_ff)
            leb_cnt_ff <= LEB_LOAD;
        else if (blanking)
            leb_cnt_ff <= leb_cnt_ff - 1'b1;
    end

    // APB slave, one wait state
    wire apb_access = psel && penable;
    wire apb_done = apb_access && pready_ff;
    wire hit_ctrl = (paddr == `PFC_OFS_CTRL);
    wire hit_status = (paddr == `PFC_OFS_STATUS);
    reg [31:0] status_word;

    always @*
    begin
        status_word = 32'h00000000;
        status_word[`PFC_ST_MODE_LSB +: `PFC_MODE_W] = mode_ff;
        status_word[`PFC_ST_GATE] = gate_drive_ff;
        status_word[`PFC_ST_BIAS] = bias_enable_ff;
        status_word[`PFC_ST_DISCH] = comp_discharge_ff;
        status_word[`PFC_ST_UV] = undervolt;
        status_word[`PFC_ST_BO] = brownout;
        status_word[`PFC_ST_OL] = open_loop;
        status_word[`PFC_ST_OV] = s_ov_trip;
        status_word[`PFC_ST_PEAK] = s_peak;
        status_word[`PFC_ST_BLANK] = blanking;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            ctrl_ff <= `PFC_CTRL_RESET;
        end
        else
        begin
            pready_ff <= apb_access && !pready_ff;
            if (apb_access && !pready_ff)
            begin
                pslverr_ff <= !(hit_ctrl || hit_status) ||
                    (pwrite && hit_status);
                if (!pwrite && hit_ctrl)
                    prdata_ff <= ctrl_ff;
                else if (!pwrite && hit_status)
                    prdata_ff <= status_word;
                else
                    prdata_ff <= 32'h00000000;
            end
            else if (!apb_access)
            begin
                pslverr_ff <= 1'b0;
            end
            // Only the sleep bit is kept; others read zero
            if (apb_done && pwrite && hit_ctrl)
                ctrl_ff[`PFC_CTRL_SLEEP] <= pwdata[`PFC_CTRL_SLEEP];
        end
    end

endmodule // pfc_mode_ctrl

/* hdl/pfc_sync.v */
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_sync #(
    parameter WIDTH = `PFC_NUM_FLAGS
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Flags
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta_ff;
            reg stable_ff;
            // First stage feeds only the second stage
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_ff <= 1'b0;
                    stable_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= async_in[i];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_out[i] = stable_ff;
        end
    endgenerate

endmodule // pfc_sync

/* tb/pfc_comparator_model.sv */
`timescale 1ns/1ps

module pfc_comparator_model #(
    // Threshold codes, plain defaults
    parameter VCC_ON = 8'h80,
    parameter VCC_OFF = 8'h60,
    parameter EN_SLEEP = 8'h10,
    parameter BO_EN = 8'h50,
    parameter BO_TRIP = 8'h40,
    parameter OPEN_LOOP = 8'h30,
    parameter OV_TRIP = 8'hD0,
    parameter OV_RST = 8'hC0,
    parameter PEAK = 8'h90,
    parameter COMP_START = 8'h20,
    parameter COMP_TOP = 8'hF0
) (
    // Sensed levels
    input logic [7:0] vcc,
    input logic [7:0] en,
    input logic [7:0] line,
    input logic [7:0] fb,
    input logic [7:0] isense,
    input logic [7:0] comp,
    // Flags
    output logic supply_above_on,
    output logic supply_below_off,
    output logic enable_below_sleep,
    output logic brownout_below_release,
    output logic brownout_below_trip,
    output logic feedback_below_open_loop,
    output logic enable_above_ov_trip,
    output logic enable_below_ov_release,
    output logic current_above_peak,
    output logic comp_below_start,
    output logic comp_at_top
);
    // Plain level compares, hysteresis is left to the controller
    assign supply_above_on = vcc > VCC_ON;
    assign supply_below_off = vcc < VCC_OFF;
    assign enable_below_sleep = en < EN_SLEEP;
    assign brownout_below_release = line < BO_EN;
    assign brownout_below_trip = line < BO_TRIP;
    assign feedback_below_open_loop = fb < OPEN_LOOP;
    assign enable_above_ov_trip = en > OV_TRIP;
    assign enable_below_ov_release = en < OV_RST;
    assign current_above_peak = isense > PEAK;
    assign comp_below_start = comp < COMP_START;
    assign comp_at_top = comp >= COMP_TOP;
endmodule // pfc_comparator_model

/* tb/pfc_mode_ctrl_monitor.sv */
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_mode_ctrl_monitor (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Flags
    input wire supply_below_off,
    input wire enable_below_sleep,
    input wire enable_above_ov_trip,
    input wire current_above_peak,
    input wire comp_below_start,
    // Outputs
    input wire gate_drive_ff,
    input wire bias_enable_ff,
    input wire comp_discharge_ff,
    input wire [`PFC_MODE_W-1:0] mode_ff
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire run = mode_ff == `PFC_MODE_SOFT || mode_ff == `PFC_MODE_NORMAL;
    wire fault = mode_ff == `PFC_MODE_OVERV || mode_ff == `PFC_MODE_PEAK;
    wire idle = !run && !fault;

    property p_gate_run;
        gate_drive_ff |-> run;
    endproperty
    a_gate_run: assert property (p_gate_run)
        else $error("gate on outside run modes");
    property p_bias;
        bias_enable_ff == (mode_ff != `PFC_MODE_SLEEP);
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias does not follow mode");
    property p_gate_comp;
        gate_drive_ff |-> !$past(comp_below_start, 3);
    endproperty
    a_gate_comp: assert property (p_gate_comp)
        else $error("gate on with error amp low");
    property p_uv;
        $rose(supply_below_off) |-> ##[1:5] mode_ff == `PFC_MODE_SLEEP;
    endproperty
    a_uv: assert property (p_uv)
        else $error("no sleep after supply drop");
    property p_pin;
        $rose(enable_below_sleep) |-> ##[1:5]
            (mode_ff == `PFC_MODE_SLEEP || mode_ff == `PFC_MODE_DISCH);
    endproperty
    a_pin: assert property (p_pin)
        else $error("sleep pin ignored");
    property p_fault_src;
        $rose(fault) |-> $past(run);
    endproperty
    a_fault_src: assert property (p_fault_src)
        else $error("fault mode entered from idle");
    property p_ov_in;
        $rose(mode_ff == `PFC_MODE_OVERV) |-> $past(enable_above_ov_trip, 3);
    endproperty
    a_ov_in: assert property (p_ov_in)
        else $error("overvoltage mode without trip");
    property p_pk_in;
        $rose(mode_ff == `PFC_MODE_PEAK) |-> $past(current_above_peak, 3);
    endproperty
    a_pk_in: assert property (p_pk_in)
        else $error("peak mode without peak flag");
    property p_disch;
        (!comp_below_start)[*4] ##0 idle |-> comp_discharge_ff;
    endproperty
    a_disch: assert property (p_disch)
        else $error("error amp not discharged");
    property p_soft_in;
        $rose(mode_ff == `PFC_MODE_SOFT) && !$past(fault)
            |-> $past(comp_below_start, 3);
    endproperty
    a_soft_in: assert property (p_soft_in)
        else $error("soft start with pre-bias");
endmodule // pfc_mode_ctrl_monitor

bind pfc_mode_ctrl pfc_mode_ctrl_monitor u_pfc_mode_ctrl_monitor (
    .pclk,
    .presetn,
    .supply_below_off,
    .enable_below_sleep,
    .enable_above_ov_trip,
    .current_above_peak,
    .comp_below_start,
    .gate_drive_ff,
    .bias_enable_ff,
    .comp_discharge_ff,
    .mode_ff
);

/* tb/pfc_operating_mode_controller_tb.sv */
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_operating_mode_controller_tb;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, pwm_request = 0;
    logic [7:0] vcc = 8'h00, en = 8'hA0, line = 8'h00;
    logic [7:0] fb = 8'h00, isense = 8'h00, comp = 8'h10;
    logic supply_above_on, supply_below_off, enable_below_sleep;
    logic brownout_below_release, brownout_below_trip;
    logic feedback_below_open_loop, enable_above_ov_trip;
    logic enable_below_ov_release, current_above_peak;
    logic comp_below_start, comp_at_top;
    logic gate_drive_ff, bias_enable_ff, comp_discharge_ff;
    logic [2:0] mode_ff;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int samples_checked = 0;

    pfc_comparator_model u_pfc_comparator_model (.vcc, .en, .line, .fb,
        .isense, .comp, .supply_above_on, .supply_below_off,
        .enable_below_sleep, .brownout_below_release, .brownout_below_trip,
        .feedback_below_open_loop, .enable_above_ov_trip,
        .enable_below_ov_release, .current_above_peak, .comp_below_start,
        .comp_at_top);
    pfc_mode_ctrl u_pfc_mode_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata_ff, .pready_ff, .pslverr_ff,
        .supply_above_on, .supply_below_off, .enable_below_sleep,
        .brownout_below_release, .brownout_below_trip,
        .feedback_below_open_loop, .enable_above_ov_trip,
        .enable_below_ov_release, .current_above_peak, .comp_below_start,
        .comp_at_top, .pwm_request, .gate_drive_ff, .bias_enable_ff,
        .comp_discharge_ff, .mode_ff);

    initial
    begin
        forever #20 pclk = ~pclk;
    end

    task automatic summarize;
        begin
            $display("checks %0d errors %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        begin
            samples_checked++;
            if (s !== e)
            begin
                error_cnt++;
                $display("unexpected %s expected %0h seen %0h", nm, e, s);
            end
        end
    endtask

    // Flags take three edges to reach the outputs, four for supply and line, six is margin
    task automatic look(input logic [2:0] m, input logic g, input logic b);
        begin
            repeat (6) @(posedge pclk);
            #1;
            chk("mode", mode_ff, m);
            chk("gate", gate_drive_ff, g);
            chk("bias", bias_enable_ff, b);
            @(posedge pclk);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // No cycle count assumed; the watchdog ends a hang
            while (pready_ff !== 1'b1)
                @(posedge pclk);
            rd = prdata_ff;
            err = pslverr_ff;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic t_startup;
        begin
            look(`PFC_MODE_SLEEP, 1'b0, 1'b0);
            vcc <= 8'hA0;
            fb <= 8'h60;
            line <= 8'h48;
            comp <= 8'h60;
            look(`PFC_MODE_STANDBY, 1'b0, 1'b1);
            chk("disch", comp_discharge_ff, 1'b1);
            line <= 8'h60;
            look(`PFC_MODE_STANDBY, 1'b0, 1'b1);
            comp <= 8'h10;
            pwm_request <= 1'b1;
            look(`PFC_MODE_SOFT, 1'b0, 1'b1);
            comp <= 8'h60;
            look(`PFC_MODE_SOFT, 1'b1, 1'b1);
            comp <= 8'hF8;
            look(`PFC_MODE_NORMAL, 1'b1, 1'b1);
            line <= 8'h48;
            look(`PFC_MODE_NORMAL, 1'b1, 1'b1);
        end
    endtask

    task automatic t_faults;
        begin
            en <= 8'hD8;
            look(`PFC_MODE_OVERV, 1'b0, 1'b1);
            en <= 8'hC8;
            look(`PFC_MODE_OVERV, 1'b0, 1'b1);
            en <= 8'hA0;
            look(`PFC_MODE_NORMAL, 1'b1, 1'b1);
            isense <= 8'h98;
            look(`PFC_MODE_PEAK, 1'b0, 1'b1);
            isense <= 8'h50;
            look(`PFC_MODE_NORMAL, 1'b1, 1'b1);
            // Short spike right after a fresh turn-on must be ignored
            pwm_request <= 1'b0;
            look(`PFC_MODE_NORMAL, 1'b0, 1'b1);
            pwm_request <= 1'b1;
            repeat (3) @(posedge pclk);
            isense <= 8'h98;
            repeat (2) @(posedge pclk);
            isense <= 8'h50;
            repeat (2) @(posedge pclk);
            #1;
            chk("blank mode", mode_ff, `PFC_MODE_NORMAL);
            chk("blank gate", gate_drive_ff, 1'b1);
            look(`PFC_MODE_NORMAL, 1'b1, 1'b1);
            fb <= 8'h20;
            look(`PFC_MODE_STANDBY, 1'b0, 1'b1);
            chk("disch", comp_discharge_ff, 1'b1);
            en <= 8'hD8;
            look(`PFC_MODE_STANDBY, 1'b0, 1'b1);
            en <= 8'hA0;
            comp <= 8'h10;
            look(`PFC_MODE_STANDBY, 1'b0, 1'b1);
            chk("disch", comp_discharge_ff, 1'b0);
            fb <= 8'h60;
            look(`PFC_MODE_SOFT, 1'b0, 1'b1);
        end
    endtask

    task automatic t_sleep;
        begin
            comp <= 8'h60;
            en <= 8'h08;
            look(`PFC_MODE_DISCH, 1'b0, 1'b1);
            chk("disch", comp_discharge_ff, 1'b1);
            comp <= 8'h10;
            look(`PFC_MODE_SLEEP, 1'b0, 1'b0);
            en <= 8'hA0;
            look(`PFC_MODE_SOFT, 1'b0, 1'b1);
            apb(1'b0, `PFC_OFS_STATUS, 32'h0);
            chk("status", rd & 32'h7F, 32'h22);
            chk("err", err, 1'b0);
            apb(1'b1, `PFC_OFS_CTRL, 32'h1);
            look(`PFC_MODE_SLEEP, 1'b0, 1'b0);
            apb(1'b1, `PFC_OFS_CTRL, 32'h0);
            look(`PFC_MODE_SOFT, 1'b0, 1'b1);
            apb(1'b0, 12'h008, 32'h0);
            chk("unmapped err", err, 1'b1);
            chk("unmapped data", rd, 32'h0);
            apb(1'b1, `PFC_OFS_STATUS, 32'h0);
            chk("ro err", err, 1'b1);
            vcc <= 8'h50;
            look(`PFC_MODE_SLEEP, 1'b0, 1'b0);
            vcc <= 8'h70;
            look(`PFC_MODE_SLEEP, 1'b0, 1'b0);
        end
    endtask

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_startup();
        t_faults();
        t_sleep();
        summarize();
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        summarize();
    end
endmodule // pfc_operating_mode_controller_tb
